// *** dv/mdd_ext_bus_model.sv ***
`timescale 1ns/1ns
module mdd_ext_bus_model (
  input  wire logic            clk,
  input  wire logic [7:0]      p0_out,
  input  wire logic            p0_oe,
  input  wire logic [7:0]      p2_out,
  input  wire logic            ale,
  input  wire logic            rd_n,
  input  wire logic            wr_n,
  input  wire logic [3:0]      p4_out,
  input  wire logic [3:0]      p4_oe,
  output logic      [7:0]      p0_in,
  output int                   n_ale,
  output logic      [3:0][7:0] cs_cnt
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q;
  logic [7:0]  last_q;
  logic [3:0]  cs_q;
  initial begin
    n_ale = 0;
    cs_cnt = '0;
    last_q = 8'h00;
    cs_q = 4'hf;
  end
  always @(posedge clk) begin
    if (ale) begin
      addr_q <= {p2_out, p0_out};
      n_ale <= n_ale + 1;
    end
    if (!wr_n)
      mem[addr_q] <= p0_out;
    if (!rd_n)
      last_q <= mem[addr_q];
    for (int i = 0; i < 4; i++) begin
      if (p4_oe[i] && cs_q[i] && !p4_out[i])
        cs_cnt[i] <= cs_cnt[i] + 8'h01;
    end
    cs_q <= p4_out;
  end
  // A released bus shows the inverse of the last byte so a stale copy cannot pass
  assign p0_in = p0_oe ? p0_out : (!rd_n ? mem[addr_q] : ~last_q);
endmodule // mdd_ext_bus_model

// *** dv/mdd_movx_properties.sv ***
`timescale 1ns/1ns
module mdd_movx_properties #(
  parameter int AUX_BYTES     = 2048,
  parameter int STROBE_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        movx_req,
  input wire logic        movx_busy,
  input wire logic        movx_done,
  input wire logic [15:0] movx_addr,
  input wire logic [7:0]  movx_wdata,
  input wire logic [7:0]  p0_out,
  input wire logic        p0_oe,
  input wire logic [7:0]  p2_out,
  input wire logic        p2_oe,
  input wire logic        ale,
  input wire logic        rd_n,
  input wire logic        wr_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Strobe length is written for the default of four cycles
  sequence s_take_ext; movx_req && !movx_busy && movx_addr >= AUX_BYTES; endsequence
  sequence s_rd_strobe; !rd_n [*4] ##1 rd_n; endsequence
  sequence s_wr_strobe; !wr_n [*4] ##1 wr_n; endsequence
  chk_high_addr_out: assert property (s_take_ext |=> ale && p2_oe &&
    {p2_out, 8'h00} == ($past(movx_addr) & 16'hff00)) else $error("upper address missing");
  chk_ale_one_pulse: assert property (ale |=> !ale && rd_n && wr_n ##1 (!rd_n || !wr_n))
    else $error("latch pulse wrong");
  chk_ale_addr_phase: assert property (ale |-> p0_oe && movx_busy && rd_n && wr_n)
    else $error("address phase wrong");
  chk_rd_strobe_len: assert property ($fell(rd_n) |-> s_rd_strobe)
    else $error("read strobe length");
  chk_wr_strobe_len: assert property ($fell(wr_n) |-> s_wr_strobe)
    else $error("write strobe length");
  chk_rd_bus_free: assert property (!rd_n |-> !p0_oe && p2_oe)
    else $error("bus not released on read");
  chk_wr_data_out: assert property ($fell(wr_n) |-> p0_oe && p0_out == $past(movx_wdata, 3))
    else $error("write data wrong");
  chk_done_at_end: assert property ($rose(rd_n) || $rose(wr_n) |-> movx_done && !movx_busy)
    else $error("completion missing");
  chk_one_strobe: assert property (rd_n || wr_n)
    else $error("both strobes low");
endmodule // mdd_movx_properties

bind mdd_movx_decoder mdd_movx_properties #(
  .AUX_BYTES    (AUX_BYTES),
  .STROBE_CYCLES(STROBE_CYCLES)
) i_chk (.*);

// *** dv/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic            clk, rst, reg_wr, reg_rd, movx_req, movx_we, flash_busy, flash_op_done;
  logic            movx_done, movx_busy, movx_rd_invalid, flash_rd_en, flash_erase_req;
  logic            flash_prog_req, p0_oe, p2_oe, ale, wr_n, rd_n;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, movx_wdata, movx_rdata, flash_rdata;
  logic [7:0]      p0_in, p0_out, p2_out, rdata_s;
  logic [15:0]     movx_addr;
  logic [10:0]     flash_rd_addr;
  logic [3:0]      p4_in, p4_out, p4_oe;
  logic [3:0][7:0] cs_cnt;
  int              n_fail = 0, n_checks = 0, n_ale, k;

  mdd_movx_decoder i_dut (.*);
  mdd_ext_bus_model i_mem (.*);
  assign flash_rdata = flash_rd_addr[7:0] ^ 8'h5a;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic reg_io(logic we, logic [7:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= we;
    reg_rd <= !we;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Read data stand only in this cycle; sample them away from the edges
    @(negedge clk);
    rdata_s = reg_rdata;
    @(posedge clk);
  endtask

  task automatic movx(logic we, logic [15:0] a, logic [7:0] d);
    movx_we <= we;
    movx_addr <= a;
    movx_wdata <= d;
    movx_req <= 1'b1;
    @(posedge clk);
    movx_req <= 1'b0;
    for (k = 0; k < 50 && movx_done !== 1'b1; k++) @(posedge clk);
    check("movx done", movx_done, 1);
  endtask

  // Tests need just over a hundred cycles; this margin only cuts a hang
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end

  initial begin
    {rst, reg_wr, reg_rd, movx_req, movx_we, flash_busy, flash_op_done} = 7'h7f & 7'h40;
    {reg_addr, reg_wdata, movx_wdata, movx_addr} = '0;
    p4_in = 4'h9;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reg_io(0, 8'h87, 8'h00); check("pmr", rdata_s, 0);
    reg_io(0, 8'h9f, 8'h00); check("dfc", rdata_s, 0);
    reg_io(0, 8'h10, 8'h00); check("unmapped", rdata_s, 0);
    reg_io(0, 8'ha5, 8'h00); check("p4 pins", rdata_s, 8'h09);
    for (logic [7:0] i = 0; i < 4; i++) begin
      reg_io(1, 8'hb0 + i, 8'h01);
      reg_io(1, 8'hb4 + i, 8'h23);
    end
    reg_io(1, 8'hb8, 8'h21);
    reg_io(1, 8'hb9, 8'h03);
    movx(1, 16'h0123, 8'h3c);
    movx(0, 16'h0123, 8'h00);
    check("ext read", movx_rdata, 8'h3c);
    check("cs count", cs_cnt, 32'h00020101);
    movx(1, 16'h1123, 8'h77);
    movx(0, 16'h1123, 8'h00);
    check("ext high", i_mem.mem[16'h1123], 8'h77);
    check("cs no match", cs_cnt, 32'h00020101);
    reg_io(1, 8'h87, 8'h01);
    movx(1, 16'h07ff, 8'ha5);
    movx(0, 16'h07ff, 8'h00);
    check("aux read", movx_rdata, 8'ha5);
    check("aux ale", n_ale, 4);
    movx(1, 16'h0800, 8'h5e);
    check("above window", i_mem.mem[16'h0800], 8'h5e);
    reg_io(1, 8'h87, 8'h00);
    reg_io(1, 8'h9f, 8'h20);
    movx(0, 16'h0010, 8'h00);
    check("flash read", movx_rdata, 8'h4a);
    check("flash addr", flash_rd_addr, 11'h010);
    check("flash valid", movx_rd_invalid, 0);
    movx(1, 16'h0010, 8'h11);
    movx(0, 16'h0800, 8'h00);
    check("flash beyond", movx_rdata, 8'h5e);
    check("flash ale", n_ale, 6);
    reg_io(1, 8'h9f, 8'ha0);
    check("erase req", flash_erase_req, 1);
    check("prog req", flash_prog_req, 0);
    flash_busy <= 1'b1;
    movx(0, 16'h0010, 8'h00);
    check("busy read", movx_rd_invalid, 1);
    flash_busy <= 1'b0;
    flash_op_done <= 1'b1;
    @(posedge clk);
    flash_op_done <= 1'b0;
    reg_io(0, 8'h9f, 8'h00);
    check("ctrl after op", rdata_s, 8'h20);
    end_sim();
  end
endmodule // testbench

// *** hdl/mdd_movx_decoder.sv ***
`timescale 1ns/1ns
`include "mdd_consts.svh"
module mdd_movx_decoder #(
  parameter int AUX_BYTES     = `MDD_AUX_BYTES,
  parameter int STROBE_CYCLES = `MDD_STROBE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        movx_req,
  input  wire logic        movx_we,
  input  wire logic [15:0] movx_addr,
  input  wire logic [7:0]  movx_wdata,
  output logic      [7:0]  movx_rdata,
  output logic             movx_done,
  output logic             movx_busy,
  output logic             movx_rd_invalid,
  output logic      [10:0] flash_rd_addr,
  output logic             flash_rd_en,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic        flash_busy,
  input  wire logic        flash_op_done,
  output logic             flash_erase_req,
  output logic             flash_prog_req,
  input  wire logic [7:0]  p0_in,
  output logic      [7:0]  p0_out,
  output logic             p0_oe,
  output logic      [7:0]  p2_out,
  output logic             p2_oe,
  output logic             ale,
  output logic             wr_n,
  output logic             rd_n,
  input  wire logic [3:0]  p4_in,
  output logic      [3:0]  p4_out,
  output logic      [3:0]  p4_oe
);
  import mdd_pkg::*;

  localparam int AW = $clog2(AUX_BYTES);

  generate
    if (AUX_BYTES != 1024 && AUX_BYTES != 2048) begin : g_bad_size
      $error("AUX_BYTES must be 1024 or 2048");
    end
    if (STROBE_CYCLES < 3 || STROBE_CYCLES > 15) begin : g_bad_strobe
      $error("STROBE_CYCLES must lie in 3..15");
    end
  endgenerate

  // Register file
  logic [7:0]  pmr_q;
  logic [7:0]  dfc_q;
  logic [3:0]  p4_latch_q;
  logic [7:0]  cfg_a_q;
  logic [7:0]  cfg_b_q;
  logic [7:0]  cs_hi_q [4];
  logic [7:0]  cs_lo_q [4];
  logic [7:0]  aux_mem [AUX_BYTES];

  // Pin synchronisers
  logic [7:0]  p0_s1_q;
  logic [7:0]  p0_s2_q;
  logic [3:0]  p4_s1_q;
  logic [3:0]  p4_s2_q;

  // Access engine
  mdd_state_t  state_q;
  mdd_state_t  state_d;
  logic [3:0]  cnt_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic        we_q;

  wire aux_en     = pmr_q[`MDD_PMR_AUX_EN];
  wire dflash_sel = dfc_q[`MDD_DFC_SELECT];
  wire in_window  = (movx_addr[15:AW] == '0);
  wire go_flash   = dflash_sel && in_window;
  wire go_aux     = !dflash_sel && aux_en && in_window;
  wire go_ext     = !go_flash && !go_aux;
  wire take       = movx_req && (state_q == MDD_ST_IDLE);
  wire strobe_end = (state_q == MDD_ST_STROBE) && (cnt_q == 4'(STROBE_CYCLES - 1));
  wire flash_bad  = (dfc_q[`MDD_DFC_ERASE] || dfc_q[`MDD_DFC_PROG]) && flash_busy;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MDD_ST_IDLE: begin
        if (take && go_ext) begin
          state_d = MDD_ST_ALE;
        end else if (take && go_flash && !movx_we) begin
          state_d = MDD_ST_FLASH;
        end
      end
      MDD_ST_ALE:    state_d = MDD_ST_HOLD;
      MDD_ST_HOLD:   state_d = MDD_ST_STROBE;
      MDD_ST_STROBE: state_d = strobe_end ? MDD_ST_IDLE : MDD_ST_STROBE;
      MDD_ST_FLASH:  state_d = MDD_ST_IDLE;
      default:       state_d = MDD_ST_IDLE;
    endcase
  end

  wire strobe_d = (state_d == MDD_ST_STROBE);

  // Register decode
  wire wr_pmr = reg_wr && (reg_addr == `MDD_OFS_PMR);
  wire wr_dfc = reg_wr && (reg_addr == `MDD_OFS_DFC);
  wire wr_p4  = reg_wr && (reg_addr == `MDD_OFS_P4);
  wire wr_cfa = reg_wr && (reg_addr == `MDD_OFS_CFG_A);
  wire wr_cfb = reg_wr && (reg_addr == `MDD_OFS_CFG_B);

  // Chip-select pins, one slice per pin
  logic [3:0] p4_out_d;
  logic [3:0] p4_oe_d;
  logic [3:0] p4_rd_map;
  logic [7:0] p4_rd_base [4];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      wire [7:0]  cfg    = (gi < 2) ? cfg_a_q : cfg_b_q;
      wire [1:0]  mode   = cfg[4*(gi%2) +: 2];
      wire        match  = (addr_q == {cs_hi_q[gi], cs_lo_q[gi]});
      wire        dir_ok = (mode == MDD_MODE_READ  && !we_q) ||
                           (mode == MDD_MODE_WRITE &&  we_q) ||
                           (mode == MDD_MODE_BOTH);
      wire        cs_on  = strobe_d && match && dir_ok;
      assign p4_out_d[gi] = (mode == MDD_MODE_GPIO) ? 1'b0 : !cs_on;
      // Quasi-bidirectional: drive only a low latch, let the pull-up make a high
      assign p4_oe_d[gi]  = (mode == MDD_MODE_GPIO) ? !p4_latch_q[gi] : 1'b1;
      always_ff @(posedge clk) begin
        if (rst) begin
          cs_hi_q[gi] <= `MDD_CS_BASE_RST;
          cs_lo_q[gi] <= `MDD_CS_BASE_RST;
        end else begin
          if (reg_wr && reg_addr == `MDD_OFS_CS_HI0 + 8'(gi)) begin
            cs_hi_q[gi] <= reg_wdata;
          end
          if (reg_wr && reg_addr == `MDD_OFS_CS_LO0 + 8'(gi)) begin
            cs_lo_q[gi] <= reg_wdata;
          end
        end
      end
      assign p4_rd_map[gi]  = (reg_addr == `MDD_OFS_CS_HI0 + 8'(gi)) ||
                              (reg_addr == `MDD_OFS_CS_LO0 + 8'(gi));
      assign p4_rd_base[gi] = (reg_addr == `MDD_OFS_CS_HI0 + 8'(gi)) ? cs_hi_q[gi] :
                              cs_lo_q[gi];
    end
  endgenerate

  wire [7:0] base_rd = p4_rd_map[0] ? p4_rd_base[0] :
                       p4_rd_map[1] ? p4_rd_base[1] :
                       p4_rd_map[2] ? p4_rd_base[2] :
                       p4_rd_map[3] ? p4_rd_base[3] : 8'h00;

  // Unmapped offsets read as zero
  wire [7:0] reg_rd_d = (reg_addr == `MDD_OFS_PMR)   ? pmr_q :
                        (reg_addr == `MDD_OFS_DFC)   ? dfc_q :
                        (reg_addr == `MDD_OFS_P4)    ? {4'h0, p4_s2_q} :
                        (reg_addr == `MDD_OFS_CFG_A) ? cfg_a_q :
                        (reg_addr == `MDD_OFS_CFG_B) ? cfg_b_q : base_rd;

  // Completion of hardware clear must not lose a same-cycle software set
  wire [7:0] dfc_w   = wr_dfc ? reg_wdata : dfc_q;
  wire       op_clr  = flash_op_done && !wr_dfc;
  wire [7:0] dfc_d   = op_clr ? (dfc_w & 8'h3f) : dfc_w;

  always_ff @(posedge clk) begin
    if (rst) begin
      pmr_q      <= `MDD_PMR_RST;
      dfc_q      <= `MDD_DFC_RST;
      p4_latch_q <= `MDD_P4_LATCH_RST;
      cfg_a_q    <= `MDD_CFG_RST;
      cfg_b_q    <= `MDD_CFG_RST;
      reg_rdata  <= 8'h00;
    end else begin
      if (wr_pmr) begin
        pmr_q <= reg_wdata;
      end
      dfc_q <= dfc_d;
      if (wr_p4) begin
        p4_latch_q <= reg_wdata[3:0];
      end
      if (wr_cfa) begin
        cfg_a_q <= reg_wdata;
      end
      if (wr_cfb) begin
        cfg_b_q <= reg_wdata;
      end
      reg_rdata <= reg_rd ? reg_rd_d : 8'h00;
    end
  end

  // Synchronisers: second stage is the only reader of the first
  always_ff @(posedge clk) begin
    if (rst) begin
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
      p4_s1_q <= 4'hf;
      p4_s2_q <= 4'hf;
    end else begin
      p0_s1_q <= p0_in;
      p0_s2_q <= p0_s1_q;
      p4_s1_q <= p4_in;
      p4_s2_q <= p4_s1_q;
    end
  end

  // Aux RAM has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (take && go_aux && movx_we) begin
      aux_mem[movx_addr[AW-1:0]] <= movx_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= MDD_ST_IDLE;
      cnt_q   <= 4'h0;
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
      we_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_q == MDD_ST_STROBE) ? cnt_q + 4'h1 : 4'h0;
      if (take) begin
        addr_q  <= movx_addr;
        wdata_q <= movx_wdata;
        we_q    <= movx_we;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      movx_rdata      <= 8'h00;
      movx_done       <= 1'b0;
      movx_busy       <= 1'b0;
      movx_rd_invalid <= 1'b0;
      flash_rd_addr   <= 11'h000;
      flash_rd_en     <= 1'b0;
      flash_erase_req <= 1'b0;
      flash_prog_req  <= 1'b0;
    end else begin
      movx_done       <= 1'b0;
      flash_rd_en     <= 1'b0;
      movx_busy       <= (state_d != MDD_ST_IDLE);
      flash_erase_req <= dfc_d[`MDD_DFC_ERASE];
      flash_prog_req  <= dfc_d[`MDD_DFC_PROG];
      if (take && go_aux) begin
        movx_done <= 1'b1;
        if (!movx_we) begin
          movx_rdata      <= aux_mem[movx_addr[AW-1:0]];
          movx_rd_invalid <= 1'b0;
        end
      end else if (take && go_flash) begin
        flash_rd_addr <= 11'(movx_addr[AW-1:0]);
        flash_rd_en   <= !movx_we;
        movx_done     <= movx_we; // Flash writes by MOVX are dropped
      end
      if (state_q == MDD_ST_FLASH) begin
        movx_rdata      <= flash_rdata;
        movx_rd_invalid <= flash_bad;
        movx_done       <= 1'b1;
      end
      if (strobe_end) begin
        // Sampled through the synchroniser, so strobe spans at least 3 cycles
        if (!we_q) begin
          movx_rdata      <= p0_s2_q;
          movx_rd_invalid <= 1'b0;
        end
        movx_done <= 1'b1;
      end
    end
  end

  // External bus pins
  always_ff @(posedge clk) begin
    if (rst) begin
      p0_out <= 8'h00;
      p0_oe  <= 1'b0;
      p2_out <= 8'h00;
      p2_oe  <= 1'b0;
      ale    <= 1'b0;
      wr_n   <= 1'b1;
      rd_n   <= 1'b1;
      p4_out <= 4'h0;
      p4_oe  <= 4'h0;
    end else begin
      ale    <= (state_d == MDD_ST_ALE);
      p2_oe  <= (state_d != MDD_ST_IDLE) && (state_d != MDD_ST_FLASH);
      p2_out <= (state_d == MDD_ST_ALE) ? movx_addr[15:8] : addr_q[15:8];
      if (state_d == MDD_ST_ALE) begin
        p0_out <= movx_addr[7:0];
        p0_oe  <= 1'b1;
      end else if (state_d == MDD_ST_HOLD) begin
        p0_out <= addr_q[7:0];
        p0_oe  <= 1'b1;
      end else begin
        p0_out <= wdata_q;
        p0_oe  <= strobe_d && we_q;
      end
      wr_n   <= !(strobe_d && we_q);
      rd_n   <= !(strobe_d && !we_q);
      p4_out <= p4_out_d;
      p4_oe  <= p4_oe_d;
    end
  end

endmodule // mdd_movx_decoder

// *** pkg/mdd_consts.svh ***
`ifndef MDD_CONSTS_SVH
`define MDD_CONSTS_SVH
// Register offsets on the 8-bit special-function port
`define MDD_OFS_PMR        8'h87
`define MDD_OFS_DFC        8'h9f
`define MDD_OFS_P4         8'ha5
`define MDD_OFS_CS_HI0     8'hb0
`define MDD_OFS_CS_LO0     8'hb4
`define MDD_OFS_CFG_A      8'hb8
`define MDD_OFS_CFG_B      8'hb9
// Field positions
`define MDD_PMR_AUX_EN     0
`define MDD_DFC_SELECT     5
`define MDD_DFC_PROG       6
`define MDD_DFC_ERASE      7
// Reset values
`define MDD_PMR_RST        8'h00
`define MDD_DFC_RST        8'h00
`define MDD_P4_LATCH_RST   4'hf
`define MDD_CFG_RST        8'h00
`define MDD_CS_BASE_RST    8'h00
// Timing count in core clock cycles; aux RAM size in bytes
`define MDD_STROBE_CYCLES  4
`define MDD_AUX_BYTES      2048
`endif

// *** pkg/mdd_pkg.sv ***
package mdd_pkg;
  typedef enum logic [4:0] {
    MDD_ST_IDLE   = 5'b00001,
    MDD_ST_ALE    = 5'b00010,
    MDD_ST_HOLD   = 5'b00100,
    MDD_ST_STROBE = 5'b01000,
    MDD_ST_FLASH  = 5'b10000
  } mdd_state_t;
  typedef enum logic [1:0] {
    MDD_MODE_GPIO  = 2'h0,
    MDD_MODE_READ  = 2'h1,
    MDD_MODE_WRITE = 2'h2,
    MDD_MODE_BOTH  = 2'h3
  } mdd_mode_t;
endpackage
